// *** hw/mcm_mode_ctrl.sv ***
// operating mode decode and negotiation steering for the media converter
`timescale 1ns/10ps
`default_nettype none

module mcm_mode_ctrl
(
    input  wire logic               clk_sys,
    input  wire logic               rstn,
    input  wire logic               pwr_up,
    input  wire logic [1:0]         speed_lvl,
    input  wire logic [1:0]         duplex_lvl,
    input  wire logic [1:0]         copper_port_level_strap,
    input  wire logic [1:0]         fiber_port_level_strap,
    input  wire logic [1:0]         addr_bit4_warning_strap,
    input  wire logic               backup_link_pin_i,
    input  wire logic               backup_link_drive,
    input  wire logic               mgmt_we,
    input  wire mcm_pkg::mcm_ctl_s  mgmt_ctl,
    input  wire mcm_pkg::mcm_line_s line_in,
    input  wire logic [3:0]         tp_partner_ab,
    output logic                    straps_latched,
    output mcm_pkg::mcm_mode_e      mode,
    output mcm_pkg::mcm_ctl_s       ctl_out,
    output mcm_pkg::mcm_strap_s     strap_out,
    output logic                    link_integrity_warning,
    output logic                    tp_out_en,
    output logic                    fo_out_en,
    output logic                    media_attachment_fo_100,
    output logic                    media_attachment_tp_100,
    output logic                    flp_gen,
    output logic                    flp_relay,
    output logic [3:0]              adv_ab,
    output logic [2:0]              resolved,
    output logic                    backup_link_pin_o,
    output logic                    backup_link_pin_oe
);
    import mcm_pkg::*;

    typedef struct packed {
        logic [2:0]   sync_pu;
        logic         latched;
        logic [CNT_W-1:0] cnt;
        mcm_strap_s   strap;
        mcm_ctl_s     ctl;
        mcm_mode_e    mode;
        mcm_an_e      an;
        logic         warn;
        logic         tp_en;
        logic         fo_en;
        logic         att_fo100;
        logic         att_tp100;
        logic         gen;
        logic         relay;
        logic [3:0]   adv;
        logic [2:0]   res;
        logic         bk_o;
        logic         bk_oe;
    } mcm_state_s;

    mcm_state_s st_reg;
    mcm_state_s st_next;

    // power-up pin through three flops, pulse the release once stage 2 and 3 agree high
    logic pu_rise;
    assign pu_rise = st_reg.sync_pu[1] & st_reg.sync_pu[2] & ~st_reg.latched & (st_reg.cnt == CNT_ZERO);

    // strap decode to discrete levels; 4-level pins keep raw codes
    function automatic mcm_lvl_e lvl3(input logic [1:0] v);
        mcm_lvl_e r;
        r = MCM_LVL_MID;
        if (v == 2'h0)
        begin
            r = MCM_LVL_GND;
        end
        else if (v == 2'h3)
        begin
            r = MCM_LVL_VCC;
        end
        return r;
    endfunction

    // strap levels mapped onto management-shaped control bits
    function automatic mcm_ctl_s strap_ctl(input mcm_lvl_e spd, input mcm_lvl_e dpx, input logic [1:0] a4);
        mcm_ctl_s c;
        c = MCM_CTL_RST;
        unique case (spd)
            MCM_LVL_GND:
            begin
                c.an_dis       = 1'b1;
                c.single_speed = 1'b1;
                c.sel_10       = 1'b1;
            end
            MCM_LVL_VCC:
            begin
                c.an_dis       = 1'b1;
                c.single_speed = 1'b1;
                c.sel_10       = 1'b0;
            end
            default:
            begin
                c.an_dis   = 1'b0;
                c.trans_n  = (dpx != MCM_LVL_MID);
                c.adv_fd_n = (dpx == MCM_LVL_GND);
            end
        endcase
        c.warn_req = (a4 != 2'h0);
        return c;
    endfunction

    // highest common ability in rank order
    function automatic logic [2:0] resolve(input logic [3:0] a);
        logic [2:0] r;
        r = MCM_RES_NONE;
        if (a[MCM_AB_100FD])
        begin
            r = MCM_RES_100FD;
        end
        else if (a[MCM_AB_100HD])
        begin
            r = MCM_RES_100HD;
        end
        else if (a[MCM_AB_10FD])
        begin
            r = MCM_RES_10FD;
        end
        else if (a[MCM_AB_10HD])
        begin
            r = MCM_RES_10HD;
        end
        return r;
    endfunction

    // next state
    always_comb
    begin
        mcm_lvl_e   spd_l;
        mcm_lvl_e   dpx_l;
        logic       nt_cond;
        logic       own_ok;
        spd_l   = MCM_LVL_MID;
        dpx_l   = MCM_LVL_MID;
        nt_cond = 1'b0;
        own_ok  = 1'b0;
        st_next = st_reg;
        st_next.sync_pu = {st_reg.sync_pu[1:0], pwr_up};

        // power-down clears the latch flag and the latch counter until release
        if (!st_reg.sync_pu[1] && !st_reg.sync_pu[2])
        begin
            st_next.latched = 1'b0;
            st_next.cnt     = CNT_ZERO;
        end
        else if (pu_rise)
        begin
            st_next.cnt = LATCH_CNT;
        end
        else if (st_reg.cnt == CNT_ONE)
        begin
            spd_l = lvl3(speed_lvl);
            dpx_l = lvl3(duplex_lvl);
            st_next.cnt               = CNT_ZERO;
            st_next.latched           = 1'b1;
            st_next.strap.speed       = spd_l;
            st_next.strap.duplex      = dpx_l;
            st_next.strap.copper_lvl  = copper_port_level_strap;
            st_next.strap.fiber_lvl   = fiber_port_level_strap;
            st_next.strap.addr4_lvl   = addr_bit4_warning_strap;
            st_next.strap.backup      = backup_link_pin_i;
            st_next.ctl = strap_ctl(spd_l, dpx_l, addr_bit4_warning_strap);
        end
        else if (st_reg.cnt != CNT_ZERO)
        begin
            st_next.cnt = st_reg.cnt - CNT_ONE;
        end

        // host writes after latching win over the straps
        if (st_reg.latched && mgmt_we)
        begin
            st_next.ctl = mgmt_ctl;
        end

        // mode from the resolved control bits
        if (st_reg.ctl.an_dis && st_reg.ctl.single_speed)
        begin
            st_next.mode = st_reg.ctl.sel_10 ? MCM_MODE_F10 : MCM_MODE_F100;
        end
        else if (!st_reg.ctl.trans_n)
        begin
            st_next.mode = MCM_MODE_TRANS;
        end
        else
        begin
            st_next.mode = st_reg.ctl.adv_fd_n ? MCM_MODE_NT_HD : MCM_MODE_NT;
        end

        // warning only in forced speed
        st_next.warn = st_reg.ctl.warn_req &
                       ((st_reg.mode == MCM_MODE_F10) | (st_reg.mode == MCM_MODE_F100));

        // four-condition gate; without fiber bursts we generate, with them we relay
        nt_cond = ((st_reg.mode == MCM_MODE_NT) | (st_reg.mode == MCM_MODE_NT_HD)) &
                  line_in.tp_flp & ~st_reg.ctl.single_speed;
        own_ok  = nt_cond & ~line_in.fo_flp;

        unique case (st_reg.an)
            MCM_AN_IDLE:
            begin
                if (own_ok)
                begin
                    st_next.an = MCM_AN_GEN;
                end
                else if (line_in.tp_flp && (nt_cond || st_reg.mode == MCM_MODE_TRANS))
                begin
                    st_next.an = MCM_AN_RELAY;
                end
            end
            MCM_AN_GEN:
            begin
                if (!line_in.tp_flp || !nt_cond)
                begin
                    st_next.an = MCM_AN_IDLE;
                end
                else if (line_in.fo_flp)
                begin
                    st_next.an = MCM_AN_RELAY;
                end
            end
            MCM_AN_RELAY:
            begin
                // fiber bursts gone in non-transparent: take over generation
                if (own_ok)
                begin
                    st_next.an = MCM_AN_GEN;
                end
                else if ((!line_in.tp_flp && !line_in.fo_flp) || !(nt_cond || st_reg.mode == MCM_MODE_TRANS))
                begin
                    st_next.an = MCM_AN_IDLE;
                end
            end
            default:
            begin
                st_next.an = MCM_AN_IDLE;
            end
        endcase

        // advertisement: speed seen on fiber, duplex from the control bits
        st_next.adv = 4'h0;
        if (st_reg.an == MCM_AN_GEN)
        begin
            st_next.adv[MCM_AB_100HD] = line_in.fo_100 & ~st_reg.ctl.adv_hd_n;
            st_next.adv[MCM_AB_10HD]  = ~line_in.fo_100 & ~st_reg.ctl.adv_hd_n;
            st_next.adv[MCM_AB_100FD] = line_in.fo_100 & ~st_reg.ctl.adv_fd_n &
                                        (st_reg.mode != MCM_MODE_NT_HD);
            st_next.adv[MCM_AB_10FD]  = ~line_in.fo_100 & ~st_reg.ctl.adv_fd_n &
                                        (st_reg.mode != MCM_MODE_NT_HD);
        end
        st_next.res = resolve(st_reg.adv & tp_partner_ab);

        // output gating and attachment selection
        unique case (st_reg.mode)
            MCM_MODE_NT, MCM_MODE_NT_HD:
            begin
                st_next.tp_en = line_in.tp_sig & line_in.fo_sig;
                st_next.fo_en = 1'b1;
                st_next.att_fo100 = line_in.tp_100;
                st_next.att_tp100 = line_in.fo_100;
            end
            MCM_MODE_TRANS:
            begin
                st_next.tp_en = 1'b1;
                st_next.fo_en = 1'b1;
                st_next.att_fo100 = line_in.tp_100;
                st_next.att_tp100 = line_in.fo_100;
            end
            default:
            begin
                st_next.tp_en = 1'b1;
                st_next.fo_en = 1'b1;
                st_next.att_fo100 = (st_reg.mode == MCM_MODE_F100);
                st_next.att_tp100 = (st_reg.mode == MCM_MODE_F100);
            end
        endcase
        if (!st_reg.latched)
        begin
            st_next.tp_en = 1'b0;
            st_next.fo_en = 1'b0;
        end

        // backup pin becomes an output once the strap is taken
        st_next.bk_oe = st_reg.latched;
        st_next.bk_o  = st_reg.latched & backup_link_drive;

        // burst flags kept as flops so the outputs need no decode after the register
        st_next.gen   = (st_next.an == MCM_AN_GEN);
        st_next.relay = (st_next.an == MCM_AN_RELAY);
    end

    // single state register; reset takes constants only
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= '{sync_pu: 3'h0, latched: 1'b0, cnt: CNT_ZERO, strap: MCM_STRAP_RST,
                        ctl: MCM_CTL_RST, mode: MCM_MODE_TRANS, an: MCM_AN_IDLE, warn: 1'b0,
                        tp_en: 1'b0, fo_en: 1'b0, att_fo100: 1'b0, att_tp100: 1'b0,
                        gen: 1'b0, relay: 1'b0,
                        adv: 4'h0, res: MCM_RES_NONE, bk_o: 1'b0, bk_oe: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign straps_latched          = st_reg.latched;
    assign mode                    = st_reg.mode;
    assign ctl_out                 = st_reg.ctl;
    assign strap_out               = st_reg.strap;
    assign link_integrity_warning  = st_reg.warn;
    assign tp_out_en               = st_reg.tp_en;
    assign fo_out_en               = st_reg.fo_en;
    assign media_attachment_fo_100 = st_reg.att_fo100;
    assign media_attachment_tp_100 = st_reg.att_tp100;
    assign flp_gen                 = st_reg.gen;
    assign flp_relay               = st_reg.relay;
    assign adv_ab                  = st_reg.adv;
    assign resolved                = st_reg.res;
    assign backup_link_pin_o       = st_reg.bk_o;
    assign backup_link_pin_oe      = st_reg.bk_oe;

endmodule

`default_nettype wire

// *** hw/mcm_pkg.sv ***
// package for the media converter mode control block
package mcm_pkg;

    // multi-level pin decode (from analog comparators)
    typedef enum logic [1:0] {
        MCM_LVL_GND  = 2'h0,
        MCM_LVL_MID  = 2'h1,
        MCM_LVL_VCC  = 2'h3
    } mcm_lvl_e;

    // operating mode, gray along f10 -> f100 -> nt_hd -> nt -> transparent
    typedef enum logic [2:0] {
        MCM_MODE_F10   = 3'h0,
        MCM_MODE_F100  = 3'h1,
        MCM_MODE_NT_HD = 3'h3,
        MCM_MODE_NT    = 3'h2,
        MCM_MODE_TRANS = 3'h6
    } mcm_mode_e;

    // negotiation link state
    typedef enum logic [1:0] {
        MCM_AN_IDLE  = 2'h0,
        MCM_AN_GEN   = 2'h1,
        MCM_AN_RELAY = 2'h3
    } mcm_an_e;

    // ability ranks, lowest to highest
    localparam logic [2:0] MCM_RES_NONE = 3'h0;
    localparam logic [2:0] MCM_RES_10HD = 3'h1;
    localparam logic [2:0] MCM_RES_10FD = 3'h2;
    localparam logic [2:0] MCM_RES_100HD = 3'h3;
    localparam logic [2:0] MCM_RES_100FD = 3'h4;

    // ability vector bit positions
    localparam int MCM_AB_10HD  = 0;
    localparam int MCM_AB_10FD  = 1;
    localparam int MCM_AB_100HD = 2;
    localparam int MCM_AB_100FD = 3;

    // strap latch window
    localparam int CLK_MHZ        = 50;
    localparam int LATCH_MIN_US   = 3;
    localparam int LATCH_MAX_US   = 8;
    localparam int LATCH_MIN_CYC  = LATCH_MIN_US * CLK_MHZ;
    localparam int LATCH_MAX_CYC  = LATCH_MAX_US * CLK_MHZ;
    localparam int LATCH_CYC      = (LATCH_MIN_CYC + LATCH_MAX_CYC) / 2;
    localparam int CNT_W          = 9;
    localparam logic [CNT_W-1:0] LATCH_CNT = CNT_W'(LATCH_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO  = 9'h000;
    localparam logic [CNT_W-1:0] CNT_ONE   = 9'h001;

    // mode control bits, management shaped
    typedef struct packed {
        logic trans_n;      // transparent select, low active
        logic adv_hd_n;     // half duplex advert, low active
        logic an_dis;       // negotiation disable
        logic adv_fd_n;     // full duplex advert, low active
        logic single_speed; // one speed only
        logic sel_10;       // forced speed is 10
        logic warn_req;     // link integrity warning request
    } mcm_ctl_s;

    localparam mcm_ctl_s MCM_CTL_RST = 7'h00;

    // decoded straps
    typedef struct packed {
        mcm_lvl_e speed;
        mcm_lvl_e duplex;
        logic [1:0] copper_lvl;
        logic [1:0] fiber_lvl;
        logic [1:0] addr4_lvl;
        logic backup;
    } mcm_strap_s;

    localparam mcm_strap_s MCM_STRAP_RST = 11'h000;

    // line status from the analog and recovery front end
    typedef struct packed {
        logic tp_sig;       // signal on twisted pair input
        logic fo_sig;       // signal on fiber input
        logic tp_flp;       // flp bursts seen on copper
        logic fo_flp;       // flp-equivalent bursts seen on fiber
        logic fo_100;       // fiber technology detected is 100
        logic tp_100;       // copper technology detected is 100
    } mcm_line_s;

endpackage

// *** bench/mcm_link_partner.sv ***
// link partner model for the copper and fiber ends of the converter
`timescale 1ns/10ps
`default_nettype none

module mcm_link_partner
(
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    input  wire logic          tp_link,
    input  wire logic          fo_link,
    input  wire logic          tp_neg,
    input  wire logic          fo_neg,
    input  wire logic          tp_fast,
    input  wire logic          fo_fast,
    input  wire logic [3:0]    tp_ab,
    input  wire logic [7:0]    burst_len,
    output mcm_pkg::mcm_line_s line_out,
    output logic [3:0]         ab_out
);
    import mcm_pkg::*;
    logic [7:0] burst_cnt_reg;

    // copper end bursts until its own count says the link is settled;
    // the converter has no say in that count, so it is kept here
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            burst_cnt_reg <= 8'h00;
            line_out      <= '0;
            ab_out        <= 4'h0;
        end
        else
        begin
            if (!tp_neg)
                burst_cnt_reg <= 8'h00;
            else if (burst_cnt_reg != burst_len)
                burst_cnt_reg <= burst_cnt_reg + 8'h01;
            line_out.tp_flp <= tp_neg && tp_link && burst_cnt_reg != burst_len;
            line_out.fo_flp <= fo_neg && fo_link; // fiber end able to negotiate
            line_out.tp_sig <= tp_link;
            line_out.fo_sig <= fo_link;
            line_out.tp_100 <= tp_fast;
            line_out.fo_100 <= fo_fast;
            ab_out          <= tp_ab;
        end
    end
endmodule
`default_nettype wire

// *** bench/mcm_mode_ctrl_properties.sv ***
// port-level checks for the mode control block
`timescale 1ns/10ps
`default_nettype none

module mcm_mode_ctrl_properties
(
    input wire logic               clk_sys,
    input wire logic               rstn,
    input wire logic               pwr_up,
    input wire logic               mgmt_we,
    input wire mcm_pkg::mcm_ctl_s  mgmt_ctl,
    input wire mcm_pkg::mcm_line_s line_in,
    input wire logic               backup_link_drive,
    input wire logic               straps_latched,
    input wire mcm_pkg::mcm_mode_e mode,
    input wire mcm_pkg::mcm_ctl_s  ctl_out,
    input wire logic               link_integrity_warning,
    input wire logic               tp_out_en,
    input wire logic               fo_out_en,
    input wire logic               media_attachment_fo_100,
    input wire logic               media_attachment_tp_100,
    input wire logic               flp_gen,
    input wire logic               flp_relay,
    input wire logic [3:0]         adv_ab,
    input wire logic               backup_link_pin_o,
    input wire logic               backup_link_pin_oe
);
    import mcm_pkg::*;
    logic       nt;
    logic       forced;
    logic [3:0] adv_exp;
    logic [9:0] lat_cnt_reg;
    logic [9:0] lat_cnt_next;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    // mode classes, expected advert, cycles since the power-down pin let go
    always_comb
    begin
        nt = straps_latched && (mode == MCM_MODE_NT || mode == MCM_MODE_NT_HD);
        forced = mode == MCM_MODE_F10 || mode == MCM_MODE_F100;
        adv_exp = line_in.fo_100 ? {~ctl_out.adv_fd_n, ~ctl_out.adv_hd_n, 2'b00}
                                 : {2'b00, ~ctl_out.adv_fd_n, ~ctl_out.adv_hd_n};
        lat_cnt_next = lat_cnt_reg;
        if (!pwr_up)
            lat_cnt_next = 10'h000;
        else if (!straps_latched && lat_cnt_reg != 10'h3ff)
            lat_cnt_next = lat_cnt_reg + 10'h001; // saturates so a hang cannot wrap
    end

    // latch delay counter
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            lat_cnt_reg <= 10'h000;
        else
            lat_cnt_reg <= lat_cnt_next;
    end

    latch_not_early_a: assert property ($rose(straps_latched) |-> lat_cnt_reg >= 10'(LATCH_MIN_CYC))
        else $error("straps latched too early");
    latch_not_late_a: assert property (lat_cnt_reg <= 10'(LATCH_MAX_CYC))
        else $error("straps latched too late");
    warn_forced_only_a: assert property (link_integrity_warning
        |-> $past(mode) inside {MCM_MODE_F10, MCM_MODE_F100})
        else $error("warning enabled outside forced modes");
    mgmt_take_a: assert property (straps_latched && mgmt_we |=> ctl_out == $past(mgmt_ctl))
        else $error("management write not taken");
    nt_tp_gate_a: assert property ((nt && !line_in.fo_flp && $stable(line_in))[*3]
        |-> tp_out_en == (line_in.tp_sig && line_in.fo_sig))
        else $error("copper output gate wrong");
    nt_fo_on_a: assert property (nt[*3] |-> fo_out_en)
        else $error("fiber output disabled");
    nt_advert_a: assert property ((nt && line_in.tp_flp && !line_in.fo_flp
        && $stable({line_in, ctl_out}))[*3] |-> adv_ab == adv_exp)
        else $error("advertised abilities wrong");
    nt_gen_a: assert property ((nt && line_in.tp_flp && !line_in.fo_flp)[*3] |-> flp_gen && !flp_relay)
        else $error("own bursts not generated");
    special_relay_a: assert property ((nt && line_in.tp_flp && line_in.fo_flp)[*3] |-> flp_relay && !flp_gen)
        else $error("special case not relaying");
    forced_no_an_a: assert property (forced[*3] |-> !flp_gen && !flp_relay)
        else $error("negotiation active in forced mode");
    trans_attach_a: assert property ((straps_latched && mode == MCM_MODE_TRANS && $stable(line_in))[*3]
        |-> media_attachment_fo_100 == line_in.tp_100 && media_attachment_tp_100 == line_in.fo_100)
        else $error("attachment does not follow opposite side");
    backup_drive_a: assert property ((straps_latched && $stable(backup_link_drive))[*4]
        |-> backup_link_pin_oe && backup_link_pin_o == backup_link_drive)
        else $error("backup pin not driven");
endmodule

bind mcm_mode_ctrl mcm_mode_ctrl_properties u_props (.*);
`default_nettype wire

// *** bench/mcm_mode_ctrl_tb.sv ***
// self-checking bench for the mode control block
`timescale 1ns/10ps
`default_nettype none

module mcm_mode_ctrl_tb;
    import mcm_pkg::*;

    typedef struct packed {
        logic [1:0] spd;
        logic [1:0] dpx;
        logic [1:0] adr;
        logic       bk;
        mcm_mode_e  md;
        mcm_ctl_s   ctl;
        logic       warn;
    } mcm_row_s;

    logic       clk_sys = 1'b0, rstn = 1'b0, pwr_up = 1'b0, mgmt_we = 1'b0, backup_link_drive = 1'b0;
    logic       bk_strap = 1'b0, tp_link = 1'b0, fo_link = 1'b0, tp_neg = 1'b0, fo_neg = 1'b0;
    logic       tp_fast = 1'b0, fo_fast = 1'b0;
    logic [1:0] speed_lvl = 2'h0, duplex_lvl = 2'h0, copper_port_level_strap = 2'h0;
    logic [1:0] fiber_port_level_strap = 2'h0, addr_bit4_warning_strap = 2'h0;
    logic [3:0] tp_ab = 4'h0, tp_partner_ab, adv_ab;
    logic [2:0] resolved;
    logic       backup_link_pin_i, straps_latched, link_integrity_warning, tp_out_en, fo_out_en;
    logic       media_attachment_fo_100, media_attachment_tp_100, flp_gen, flp_relay;
    logic       backup_link_pin_o, backup_link_pin_oe;
    mcm_mode_e  mode;
    mcm_ctl_s   mgmt_ctl = 7'h00, ctl_out;
    mcm_strap_s strap_out;
    mcm_line_s  line_in;
    int         err_count = 0, n_compared = 0;

    // strap rows: speed, duplex, address strap, backup pin, then expected mode, control, warning
    mcm_row_s rows [6] = '{
        '{2'h0, 2'h0, 2'h1, 1'b1, MCM_MODE_F10,   7'h17, 1'b1},
        '{2'h3, 2'h1, 2'h2, 1'b0, MCM_MODE_F100,  7'h15, 1'b1},
        '{2'h1, 2'h0, 2'h3, 1'b1, MCM_MODE_NT_HD, 7'h49, 1'b0},
        '{2'h3, 2'h0, 2'h0, 1'b0, MCM_MODE_F100,  7'h14, 1'b0},
        '{2'h1, 2'h2, 2'h1, 1'b0, MCM_MODE_TRANS, 7'h01, 1'b0},
        '{2'h2, 2'h3, 2'h0, 1'b1, MCM_MODE_NT,    7'h40, 1'b0}};
    // negotiation cases: fiber speed, partner abilities, advert, resolution
    logic       nfast [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [3:0] nab [5]   = '{4'hf, 4'h7, 4'h3, 4'h3, 4'h1};
    logic [3:0] nadv [5]  = '{4'hc, 4'hc, 4'hc, 4'h3, 4'h3};
    logic [2:0] nres [5]  = '{MCM_RES_100FD, MCM_RES_100HD, MCM_RES_NONE, MCM_RES_10FD, MCM_RES_10HD};

    always #10 clk_sys = ~clk_sys;
    // pin level: pull resistor sets it whenever the converter does not drive
    assign backup_link_pin_i = backup_link_pin_oe ? backup_link_pin_o : bk_strap;

    mcm_mode_ctrl DUT (.*);

    mcm_link_partner u_partner
    (
        .clk_sys(clk_sys), .rstn(rstn), .tp_link(tp_link), .fo_link(fo_link), .tp_neg(tp_neg),
        .fo_neg(fo_neg), .tp_fast(tp_fast), .fo_fast(fo_fast), .tp_ab(tp_ab), .burst_len(8'hc8),
        .line_out(line_in), .ab_out(tp_partner_ab)
    );

    task automatic end_sim;
        if (err_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    function automatic logic [1:0] lvl(input logic [1:0] v);
        return (v == 2'h0 || v == 2'h3) ? v : 2'h1;
    endfunction

    task automatic write_ctl(input mcm_ctl_s v);
        @(posedge clk_sys);
        mgmt_we <= 1'b1;
        mgmt_ctl <= v;
        @(posedge clk_sys);
        mgmt_we <= 1'b0;
    endtask

    // reset, set straps, release power-down; an early write must be ignored
    task automatic power_cycle(input mcm_row_s r, input logic [1:0] k);
        int n;
        @(posedge clk_sys);
        rstn <= 1'b0;
        pwr_up <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        {speed_lvl, duplex_lvl, addr_bit4_warning_strap, bk_strap} <= {r.spd, r.dpx, r.adr, r.bk};
        {copper_port_level_strap, fiber_port_level_strap, backup_link_drive} <= {k, ~k, ~r.bk};
        @(posedge clk_sys);
        pwr_up <= 1'b1;
        repeat (4) @(posedge clk_sys);
        write_ctl(7'h15);
        #1;
        check(backup_link_pin_oe, 1'b0);
        n = 6;
        while (straps_latched !== 1'b1 && n < 500)
        begin
            step(1);
            n++;
        end
        check(n >= LATCH_MIN_CYC && n <= LATCH_MAX_CYC, 1'b1);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        end_sim;
    end

    initial
    begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            power_cycle(rows[i], 2'(i));
            step(4);
            check(mode, rows[i].md);
            check(ctl_out, rows[i].ctl);
            check(strap_out, {lvl(rows[i].spd), lvl(rows[i].dpx), 2'(i), ~2'(i), rows[i].adr, rows[i].bk});
            check(link_integrity_warning, rows[i].warn);
            check({backup_link_pin_oe, backup_link_pin_o}, {1'b1, ~rows[i].bk});
        end
        // copper output waits for signal on both inputs, fiber output stays on
        @(posedge clk_sys);
        tp_link <= 1'b1;
        step(5);
        check({tp_out_en, fo_out_en}, 2'b01);
        @(posedge clk_sys);
        fo_link <= 1'b1;
        step(5);
        check(tp_out_en, 1'b1);
        // own bursts follow fiber speed; every rank of the resolution is visited
        @(posedge clk_sys);
        tp_neg <= 1'b1;
        for (int j = 0; j < 5; j++)
        begin
            @(posedge clk_sys);
            fo_fast <= nfast[j];
            tp_ab <= nab[j];
            step(6);
            check({flp_gen, flp_relay}, 2'b10);
            check(adv_ab, nadv[j]);
            check(resolved, nres[j]);
        end
        write_ctl(7'h48);
        step(6);
        check({mode, adv_ab}, {MCM_MODE_NT_HD, 4'h1});
        step(200);
        check(flp_gen, 1'b0);
        // fiber end negotiates too: relay instead of generating
        @(posedge clk_sys);
        {tp_neg, fo_neg} <= 2'b01;
        @(posedge clk_sys);
        tp_neg <= 1'b1;
        step(6);
        check({flp_gen, flp_relay}, 2'b01);
        // back-to-back writes: the later one wins
        @(posedge clk_sys);
        mgmt_we <= 1'b1;
        mgmt_ctl <= 7'h5f;
        @(posedge clk_sys);
        mgmt_ctl <= 7'h15;
        @(posedge clk_sys);
        mgmt_we <= 1'b0;
        step(5);
        check({mode, link_integrity_warning, flp_gen, flp_relay}, {MCM_MODE_F100, 3'b100});
        write_ctl(7'h41);
        step(5);
        check({mode, link_integrity_warning}, {MCM_MODE_NT, 1'b0});
        write_ctl(7'h01);
        @(posedge clk_sys);
        tp_fast <= 1'b1;
        step(6);
        check({mode, link_integrity_warning, flp_gen, flp_relay}, {MCM_MODE_TRANS, 3'b001});
        check({media_attachment_fo_100, media_attachment_tp_100}, 2'b10);
        // address strap is not sampled again after the latch
        @(posedge clk_sys);
        addr_bit4_warning_strap <= 2'h3;
        step(4);
        check(strap_out.addr4_lvl, 2'h0);
        end_sim;
    end
endmodule
`default_nettype wire
